// file: adc_trigger_transfer_dac_latch.sv
// conversion control, result transfer and d/a latches of the card
// assumes bus strobes and dack are single-cycle and synchronous to
// mclk; ext_trig and the two jumper levels arrive from outside
`timescale 1ns/100ps
`default_nettype none
module adc_trigger_transfer_dac_latch import adc_ctl_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// host byte bus
	input wire logic [3:0] addr,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_q,
	// host dma handshake
	input wire logic dack,
	output logic drq_q,
	// host interrupt
	output logic irq_q,
	// trigger sources and jumper levels
	input wire logic pacer_tick,
	input wire logic ext_trig,
	input wire logic ext_trig_sel,
	input wire logic diff_mode,
	// converter front end
	output logic adc_start_q,
	input wire logic [11:0] adc_data,
	output logic [3:0] input_channel_select_q,
	output logic [2:0] gain_q,
	// d/a codes
	output logic [11:0] dac0_q,
	output logic [11:0] dac1_q
);
	// ==========================================================
	// control registers
	logic [2:0] mode_q; // trigger and transfer selection
	logic [3:0] chan_q; // channel as written by the host
	logic [2:0] gain_set_q; // gain code as written by the host

	// ==========================================================
	// pin synchronisers: three stages, a change counts when the
	// second and third agree so a single glitch is filtered
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] sync3_q;
	logic [2:0] pin_lvl_q; // accepted level of each pin
	wire [2:0] agree = ~(sync2_q ^ sync3_q);
	wire [2:0] pin_lvl_d = (pin_lvl_q & ~agree) | (sync3_q & agree);
	wire ext_rise = agree[0] && sync3_q[0] && !pin_lvl_q[0];
	wire use_ext = pin_lvl_q[1]; // jumper: external versus pacer
	wire is_diff = pin_lvl_q[2]; // jumper: differential inputs

	// ==========================================================
	// conversion state
	conv_state_t conv_q;
	logic [7:0] conv_cnt_q; // busy cycles elapsed
	logic pending_q; // reads 1 while a result is awaited
	logic [11:0] pres_q; // result shown to the host
	logic pres_valid_q; // pres_q not yet consumed

	// ==========================================================
	// dma state
	dma_state_t dma_q;
	dma_state_t dma_d;

	// ==========================================================
	// address decode
	wire wr_mode = wr_stb && addr == OFS_MODE;
	wire wr_chan = wr_stb && addr == OFS_CHAN;
	wire wr_gain = wr_stb && addr == OFS_GAIN;
	wire wr_soft = wr_stb && addr == OFS_SOFT_TRIG;
	wire wr_d0_lo = wr_stb && addr == OFS_DAC0_LO;
	wire wr_d0_hi = wr_stb && addr == OFS_DAC0_HI;
	wire wr_d1_lo = wr_stb && addr == OFS_DAC1_LO;
	wire wr_d1_hi = wr_stb && addr == OFS_DAC1_HI;
	wire rd_io = rd_stb && !dack; // plain i/o read
	wire rd_dma = rd_stb && dack; // dma read cycle

	// ==========================================================
	// mode decode; undefined codes act like the disabled code
	wire m_soft = (mode_q == MODE_SOFT_POLL);
	wire m_dma = (mode_q == MODE_HW_DMA);
	wire m_irq = (mode_q == MODE_HW_IRQ);
	wire m_hw = m_dma || m_irq;

	// ==========================================================
	// trigger selection
	wire soft_req = m_soft && wr_soft;
	wire ext_req = m_hw && use_ext && ext_rise;
	wire pace_req = m_hw && !use_ext && pacer_tick;
	wire trig_req = soft_req || ext_req || pace_req;

	// ==========================================================
	// buffer hookup: a full buffer refuses new triggers, so a
	// stalled host throttles sampling instead of losing words
	wire buf_in_ready;
	wire buf_out_valid;
	wire [11:0] buf_out_data;
	wire conv_idle = (conv_q == CONV_IDLE);
	wire trig_go = trig_req && conv_idle && buf_in_ready;
	wire conv_done = (conv_q == CONV_RUN) && (conv_cnt_q == CONV_LAST);
	wire pop = buf_out_valid && !pres_valid_q;

	// ==========================================================
	// consumption: a high-byte read or the second dma byte
	wire io_take = rd_io && addr == OFS_RES_HI && pres_valid_q;
	wire dma_done = (dma_q == DMA_HI) && rd_dma;
	wire consume = io_take || dma_done;

	// ==========================================================
	// read data
	wire [7:0] rd_hi = {3'h0, pending_q, pres_q[11:8]};
	wire [7:0] rd_lo = pres_q[7:0];
	wire [7:0] rd_sel = (addr == OFS_RES_HI) ? rd_hi :
		(addr == OFS_RES_LO) ? rd_lo : 8'h00;
	wire [7:0] rd_dsel = (dma_q == DMA_HI) ? rd_hi : rd_lo;
	wire [7:0] rd_next = dack ? rd_dsel : rd_sel;

	// ==========================================================
	// channel routing: differential mode drops the top bit
	wire [3:0] chan_eff = is_diff ? {1'b0, chan_q[2:0]} : chan_q;

	// ==========================================================
	// pin sampling
	always_ff @(posedge mclk) begin
		if (srst) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
			pin_lvl_q <= 3'h0;
		end else begin
			sync1_q <= {diff_mode, ext_trig_sel, ext_trig};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_lvl_q <= pin_lvl_d;
		end
	end

	// ==========================================================
	// host-written setup registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			mode_q <= MODE_RST;
			chan_q <= CHAN_RST;
			gain_set_q <= GAIN_RST;
		end else begin
			if (wr_mode) begin
				mode_q <= wdata[2:0];
			end
			if (wr_chan) begin
				chan_q <= wdata[3:0];
			end
			if (wr_gain) begin
				gain_set_q <= wdata[2:0];
			end
		end
	end

	// ==========================================================
	// front-end outputs, registered
	always_ff @(posedge mclk) begin
		if (srst) begin
			input_channel_select_q <= CHAN_RST;
			gain_q <= GAIN_RST;
			adc_start_q <= 1'b0;
		end else begin
			input_channel_select_q <= chan_eff;
			gain_q <= gain_set_q;
			adc_start_q <= trig_go;
		end
	end

	// ==========================================================
	// conversion sequencer: fixed busy time, then capture
	always_ff @(posedge mclk) begin
		if (srst) begin
			conv_q <= CONV_IDLE;
			conv_cnt_q <= 8'h00;
		end else begin
			case (conv_q)
				CONV_IDLE: begin
					conv_cnt_q <= 8'h00;
					if (trig_go) begin
						conv_q <= CONV_RUN;
					end
				end
				CONV_RUN: begin
					conv_cnt_q <= conv_cnt_q + 8'h01;
					if (conv_done) begin
						conv_q <= CONV_IDLE;
					end
				end
				default: begin
					conv_q <= CONV_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// pending flag: a new trigger wins over a same-cycle load
	always_ff @(posedge mclk) begin
		if (srst) begin
			pending_q <= 1'b0;
		end else if (trig_go) begin
			pending_q <= 1'b1;
		end else if (pop) begin
			pending_q <= 1'b0;
		end
	end

	// ==========================================================
	// presented result; a word loads only once the last was taken
	always_ff @(posedge mclk) begin
		if (srst) begin
			pres_q <= WORD_RST;
			pres_valid_q <= 1'b0;
		end else if (pop) begin
			pres_q <= buf_out_data;
			pres_valid_q <= 1'b1;
		end else if (consume) begin
			pres_valid_q <= 1'b0;
		end
	end

	// ==========================================================
	// interrupt: raised per loaded result, dropped when taken;
	// a load in the same cycle as a take keeps it raised
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else if (pop && m_irq) begin
			irq_q <= 1'b1;
		end else if (consume) begin
			irq_q <= 1'b0;
		end
	end

	// ==========================================================
	// dma: one request per byte, dropped for a cycle between them
	// so a single-transfer controller sees two separate requests
	always_comb begin
		dma_d = dma_q;
		case (dma_q)
			DMA_IDLE: begin
				if (pop && m_dma) begin
					dma_d = DMA_LO;
				end
			end
			DMA_LO: begin
				if (rd_dma) begin
					dma_d = DMA_GAP;
				end
			end
			DMA_GAP: begin
				dma_d = DMA_HI;
			end
			DMA_HI: begin
				if (rd_dma) begin
					dma_d = DMA_IDLE;
				end
			end
			default: begin
				dma_d = DMA_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			dma_q <= DMA_IDLE;
			drq_q <= 1'b0;
		end else begin
			dma_q <= dma_d;
			drq_q <= (dma_d == DMA_LO) || (dma_d == DMA_HI);
		end
	end

	// ==========================================================
	// read data register: updated only on a read strobe
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (rd_stb) begin
			rdata_q <= rd_next;
		end
	end

	// ==========================================================
	// result buffer
	two_entry_buf #(.W(12)) u_buf (
		.mclk(mclk),
		.srst(srst),
		.in_valid(conv_done),
		.in_ready(buf_in_ready),
		.in_data(adc_data),
		.out_valid(buf_out_valid),
		.out_ready(!pres_valid_q),
		.out_data(buf_out_data)
	);

	// ==========================================================
	// two d/a channels
	dac_latch u_dac0 (
		.mclk(mclk),
		.srst(srst),
		.wr_lo(wr_d0_lo),
		.wr_hi(wr_d0_hi),
		.wdata(wdata),
		.value_q(dac0_q)
	);

	dac_latch u_dac1 (
		.mclk(mclk),
		.srst(srst),
		.wr_lo(wr_d1_lo),
		.wr_hi(wr_d1_hi),
		.wdata(wdata),
		.value_q(dac1_q)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	sequence s_dma_lo_taken;
		dma_q == DMA_LO && drq_q && rd_dma;
	endsequence

	sequence s_two_requests;
		!drq_q ##1 drq_q;
	endsequence

	chk_soft_start: assert property (
		soft_req && conv_idle && buf_in_ready |=> adc_start_q)
		else $error("soft trigger did not start a conversion");
	chk_ext_start: assert property (
		ext_req && conv_idle && buf_in_ready |=> adc_start_q)
		else $error("external edge did not start a conversion");
	chk_pacer_start: assert property (
		pace_req && conv_idle && buf_in_ready |=> adc_start_q)
		else $error("pacer tick did not start a conversion");
	chk_pend_set: assert property (
		adc_start_q |-> pending_q && conv_q == CONV_RUN)
		else $error("pending flag not set by a trigger");
	chk_pend_clear: assert property (
		pop && !trig_go |=> !pending_q && pres_valid_q)
		else $error("pending flag not cleared on result");
	chk_low_read: assert property (
		rd_io && addr == OFS_RES_LO |=> rdata_q == $past(pres_q[7:0]))
		else $error("low result byte read wrong");
	chk_flag_read: assert property (
		rd_io && addr == OFS_RES_HI |=> rdata_q[PEND_BIT] == $past(pending_q))
		else $error("pending flag bit read wrong");
	chk_irq_raise: assert property (
		pop && m_irq |=> irq_q)
		else $error("interrupt not raised on completion");
	chk_dma_pair: assert property (
		s_dma_lo_taken |=> s_two_requests)
		else $error("second dma request not issued");
	chk_busy_ignore: assert property (
		conv_q == CONV_RUN && trig_req |=> !adc_start_q)
		else $error("trigger accepted while busy");
	chk_diff_chan: assert property (
		is_diff |=> !input_channel_select_q[3])
		else $error("differential channel kept its top bit");
endmodule
`default_nettype wire

// file: adc_ctl_pkg.sv
// constants shared by the acquisition control block and its helpers
// assumes one clock, mclk at 25 MHz, and a byte-wide host i/o bus
// How it works
// - soft trigger write while idle with buffer room starts one conversion
// - external rising edge starts one conversion
// - pacer tick starts conversions periodically
// - pending flag in high byte clears when a result is presented
// - low result byte readable once flag clears
// - interrupt mode raises irq per conversion
// - dma mode raises two requests per conversion
// - two independent 12-bit dac channels
// - low byte stages, high byte commits value
// - high-only write reuses previous low byte
// - late low write leaves output unchanged
// - mode codes 0,1,2,6 decode as listed
// - channel select four bits, differential three
package adc_ctl_pkg;
	// ==========================================================
	// register offsets
	localparam logic [3:0] OFS_RES_LO = 4'h4;
	localparam logic [3:0] OFS_RES_HI = 4'h5;
	localparam logic [3:0] OFS_DAC0_LO = 4'h4;
	localparam logic [3:0] OFS_DAC0_HI = 4'h5;
	localparam logic [3:0] OFS_DAC1_LO = 4'h6;
	localparam logic [3:0] OFS_DAC1_HI = 4'h7;
	localparam logic [3:0] OFS_GAIN = 4'h9;
	localparam logic [3:0] OFS_SOFT_TRIG = 4'ha;
	localparam logic [3:0] OFS_MODE = 4'hb;
	localparam logic [3:0] OFS_CHAN = 4'hc;
	// ==========================================================
	// field positions
	localparam int PEND_BIT = 4; // pending flag inside the high byte
	// ==========================================================
	// mode codes
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_SOFT_POLL = 3'h1;
	localparam logic [2:0] MODE_HW_DMA = 3'h2;
	localparam logic [2:0] MODE_HW_IRQ = 3'h6;
	// ==========================================================
	// reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [2:0] GAIN_RST = 3'h0;
	localparam logic [3:0] CHAN_RST = 4'h0;
	localparam logic [11:0] WORD_RST = 12'h000;
	// ==========================================================
	// timing: converter busy time, rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 40;
	localparam int CONV_TIME_NS = 8000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
	// ==========================================================
	// state types
	typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;
	typedef enum logic [1:0] {DMA_IDLE, DMA_LO, DMA_GAP, DMA_HI} dma_state_t;
endpackage

// file: two_entry_buf.sv
// two-entry result buffer between the converter and the host side
// assumes both sides run on mclk; ready and valid follow the usual rules
`timescale 1ns/100ps
`default_nettype none
module two_entry_buf import adc_ctl_pkg::*; #(
	parameter int W = 12
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] slot0_q; // head entry
	logic [W-1:0] slot1_q; // second entry
	logic [1:0] count_q; // entries held
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data = slot0_q;

	// ==========================================================
	// storage: head shifts forward on a pop
	always_ff @(posedge mclk) begin
		if (srst) begin
			count_q <= 2'h0;
			slot0_q <= '0;
			slot1_q <= '0;
		end else begin
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
			if (pop) begin
				slot0_q <= (count_q == 2'h2) ? slot1_q : in_data;
			end else if (push && count_q == 2'h0) begin
				slot0_q <= in_data;
			end
			if (push && (count_q - {1'b0, pop}) == 2'h1) begin
				slot1_q <= in_data;
			end
		end
	end
endmodule
`default_nettype wire

// file: dac_latch.sv
// one double-buffered 12-bit d/a latch loaded by two byte writes
// assumes write strobes are single-cycle and synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module dac_latch import adc_ctl_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// byte writes
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	// converter code
	output logic [11:0] value_q
);
	logic [7:0] low_q; // staged low byte, never seen by the converter

	// ==========================================================
	// low byte only stages; high byte commits the whole word
	always_ff @(posedge mclk) begin
		if (srst) begin
			low_q <= WORD_RST[7:0];
			value_q <= WORD_RST;
		end else begin
			if (wr_lo) begin
				low_q <= wdata;
			end
			if (wr_hi) begin
				value_q <= {wdata[3:0], low_q};
			end
		end
	end

	// ==========================================================
	// checks
	chk_hi_commit: assert property (@(posedge mclk) disable iff (srst)
		wr_hi |=> value_q == {$past(wdata[3:0]), $past(low_q)})
		else $error("high byte write did not commit staged word");
	chk_lo_hold: assert property (@(posedge mclk) disable iff (srst)
		wr_lo && !wr_hi |=> $stable(value_q))
		else $error("low byte write changed the dac output");
endmodule
`default_nettype wire

// file: host_dma_model.sv
// host dma controller stand-in: answers each request with one single
// transfer (dack with the read strobe) after a chosen number of cycles
// assumes drq is a registered level synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module host_dma_model (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// request and answer
	input wire logic drq,
	input wire logic [3:0] delay,
	output logic dack,
	// bytes captured from the card
	input wire logic [7:0] rdata,
	output logic [15:0] bytes_q,
	output logic [3:0] n_q
);
	logic [3:0] wait_q; // cycles spent before answering
	logic [1:0] take_q; // read data is picked up two edges later
	// ==========================================================
	// one byte per request, never a burst; the guard on take_q
	// keeps a request that has not yet dropped from being served twice
	always_ff @(posedge mclk) begin
		if (srst) begin
			dack <= 1'b0;
			wait_q <= 4'h0;
			take_q <= 2'b00;
			bytes_q <= 16'h0000;
			n_q <= 4'h0;
		end else begin
			take_q <= {take_q[0], dack};
			if (take_q[1]) begin
				// newest byte enters at the top
				bytes_q <= {rdata, bytes_q[15:8]};
				n_q <= n_q + 4'h1;
			end
			if (dack) begin
				dack <= 1'b0;
			end else if (drq && take_q == 2'b00) begin
				if (wait_q == delay) begin
					dack <= 1'b1;
					wait_q <= 4'h0;
				end else begin
					wait_q <= wait_q + 4'h1; // slow answer
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: tb_adc_trigger_transfer_dac_latch.sv
// self-checking bench for the acquisition control block
// assumes the dma stand-in serves requests; one clock, mclk
`timescale 1ns/100ps
`default_nettype none
module tb_adc_trigger_transfer_dac_latch import adc_ctl_pkg::*; ;
	// ==========================================================
	// signals
	logic mclk, srst, wr_stb, host_rd, rd_stb, dack, drq_q, irq_q;
	logic pacer_tick, ext_trig, ext_trig_sel, diff_mode, adc_start_q;
	logic [3:0] addr, input_channel_select_q, dma_dly, dma_n_q;
	logic [7:0] wdata, rdata_q;
	logic [11:0] adc_data, dac0_q, dac1_q;
	logic [2:0] gain_q;
	logic [15:0] dma_bytes_q;
	int starts = 0; // converter start pulses seen
	int bad_count = 0;
	int n_compared = 0;
	// dma reads share the read strobe with the host
	assign rd_stb = host_rd | dack;
	adc_trigger_transfer_dac_latch adc_trigger_transfer_dac_latch_i (
		.mclk(mclk), .srst(srst), .addr(addr), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .wdata(wdata), .rdata_q(rdata_q), .dack(dack),
		.drq_q(drq_q), .irq_q(irq_q), .pacer_tick(pacer_tick),
		.ext_trig(ext_trig), .ext_trig_sel(ext_trig_sel),
		.diff_mode(diff_mode), .adc_start_q(adc_start_q),
		.adc_data(adc_data),
		.input_channel_select_q(input_channel_select_q),
		.gain_q(gain_q), .dac0_q(dac0_q), .dac1_q(dac1_q));
	host_dma_model host_dma_model_i (
		.mclk(mclk), .srst(srst), .drq(drq_q), .delay(dma_dly),
		.dack(dack), .rdata(rdata_q), .bytes_q(dma_bytes_q),
		.n_q(dma_n_q));
	// ==========================================================
	// clock and start counter
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (adc_start_q === 1'b1) begin
			starts <= starts + 1;
		end
	end
	// ==========================================================
	// shared tasks
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask
	// a bounded wait that ran out ends the run
	task automatic give_up(input logic ok, input string what);
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: no %s in time", $time, what);
			test_done();
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	// data is taken one edge late; it holds until the next read
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		host_rd <= 1'b1;
		@(posedge mclk);
		host_rd <= 1'b0;
		@(posedge mclk);
		#1 d = rdata_q;
	endtask
	task automatic settle();
		@(posedge mclk);
		#1;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_dac();
		wr(OFS_DAC0_LO, 8'h34);
		settle();
		chk(16'(dac0_q), 16'h0000, "low alone");
		wr(OFS_DAC0_HI, 8'hf2);
		wr(OFS_DAC1_LO, 8'h99);
		wr(OFS_DAC1_HI, 8'h0a);
		settle();
		chk(16'(dac0_q), 16'h0234, "dac0");
		chk(16'(dac1_q), 16'h0a99, "dac1");
		wr(OFS_DAC1_HI, 8'h03);
		settle();
		chk(16'(dac1_q), 16'h0399, "high only");
		wr(OFS_DAC1_LO, 8'h11);
		settle();
		chk(16'(dac1_q), 16'h0399, "late low");
		wr(OFS_DAC1_HI, 8'h04);
		settle();
		chk(16'(dac1_q), 16'h0411, "commit");
		chk(16'(dac0_q), 16'h0234, "dac0 kept");
		$display("test dac done");
	endtask
	task automatic t_poll();
		logic [7:0] d;
		int s, i;
		wr(OFS_MODE, 8'(MODE_SOFT_POLL));
		wr(OFS_CHAN, 8'h0b);
		wr(OFS_GAIN, 8'h04);
		settle();
		chk(16'(input_channel_select_q), 16'h000b, "chan");
		chk(16'(gain_q), 16'h0004, "gain");
		diff_mode <= 1'b1;
		repeat (6) settle();
		chk(16'(input_channel_select_q), 16'h0003, "diff chan");
		diff_mode <= 1'b0;
		adc_data <= 12'h9c5;
		s = starts;
		wr(OFS_SOFT_TRIG, 8'h5a);
		rd(OFS_RES_HI, d);
		chk(16'(d[PEND_BIT]), 16'h0001, "pending");
		wr(OFS_SOFT_TRIG, 8'h00);
		d = 8'hff;
		for (i = 0; i < 300 && d[PEND_BIT] !== 1'b0; i++) rd(OFS_RES_HI, d);
		give_up(d[PEND_BIT] === 1'b0, "ready");
		chk(16'(d), 16'h0009, "high byte");
		rd(OFS_RES_LO, d);
		chk(16'(d), 16'h00c5, "low byte");
		chk(16'(starts - s), 16'h0001, "one start");
		$display("test poll done");
	endtask
	// soft trigger works in mode 1 only; the rest disable it
	task automatic t_modes();
		logic [2:0] m [5] = '{MODE_OFF, MODE_HW_DMA, MODE_HW_IRQ, 3'h3, 3'h7};
		int s, i;
		for (i = 0; i < 5; i++) begin
			wr(OFS_MODE, 8'(m[i]));
			s = starts;
			wr(OFS_SOFT_TRIG, 8'hff);
			repeat (4) settle();
			chk(16'(starts - s), 16'h0000, "soft refused");
		end
		$display("test modes done");
	endtask
	// pacer with interrupt; nothing read until the buffer refuses
	task automatic t_irq();
		logic [7:0] lo, hi;
		int s, i;
		wr(OFS_MODE, 8'(MODE_HW_IRQ));
		s = starts;
		for (i = 0; i < 4; i++) begin
			adc_data <= 12'(12'h111 * (i + 1));
			@(posedge mclk);
			pacer_tick <= 1'b1;
			@(posedge mclk);
			pacer_tick <= 1'b0;
			#1 chk(16'(adc_start_q), 16'(i < 3), "pacer start");
			repeat (210) @(posedge mclk);
		end
		chk(16'(irq_q), 16'h0001, "irq up");
		chk(16'(starts - s), 16'h0003, "starts");
		for (i = 0; i < 3; i++) begin
			rd(OFS_RES_LO, lo);
			rd(OFS_RES_HI, hi);
			// word one is read while two later starts still await
			// presentation, so its flag bit still reads 1
			chk({hi, lo}, 16'(12'h111 * (i + 1)) |
				(i == 0 ? 16'h1000 : 16'h0000), "word");
		end
		repeat (2) settle();
		chk(16'(irq_q), 16'h0000, "irq down");
		$display("test irq done");
	endtask
	// external edge with dma; second pass has a slow controller
	task automatic t_dma();
		logic [3:0] n0;
		int s, i, j;
		wr(OFS_MODE, 8'(MODE_HW_DMA));
		ext_trig_sel <= 1'b1;
		repeat (6) settle();
		for (j = 0; j < 2; j++) begin
			dma_dly <= 4'(j * 5);
			adc_data <= 12'(12'h7e4 - j);
			n0 = dma_n_q;
			s = starts;
			@(posedge mclk);
			ext_trig <= 1'b1;
			repeat (8) @(posedge mclk);
			ext_trig <= 1'b0;
			chk(16'(starts - s), 16'h0001, "edge start");
			for (i = 0; i < 400 && dma_n_q !== 4'(n0 + 4'h2); i++) settle();
			give_up(dma_n_q === 4'(n0 + 4'h2), "dma pair");
			repeat (12) settle();
			chk(16'(dma_n_q - n0), 16'h0002, "two requests");
			chk(dma_bytes_q, 16'(12'h7e4 - j), "dma bytes");
		end
		$display("test dma done");
	endtask
	// ==========================================================
	// main sequence
	initial begin
		srst = 1'b1;
		addr = 4'h0;
		wr_stb = 1'b0;
		host_rd = 1'b0;
		wdata = 8'h00;
		pacer_tick = 1'b0;
		ext_trig = 1'b0;
		ext_trig_sel = 1'b0;
		diff_mode = 1'b0;
		adc_data = 12'h000;
		dma_dly = 4'h0;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		settle();
		chk(16'({irq_q, drq_q, dac0_q}), 16'h0000, "reset outputs");
		t_dac();
		t_poll();
		t_modes();
		t_irq();
		t_dma();
		test_done();
	end
endmodule
`default_nettype wire
